// >>> cdm_engine.sv
// cipher dma sequencer with event flags and poll delay registers
// assumes an avalon-mm master for registers and a req/ack memory port
//
// Notes on behaviour
// - a failed memory access sets the access error flag at bit 3.
// - finishing a descriptor's packet sets the packet done flag at bit 2.
// - finishing the last descriptor sets the processed flag at bit 1.
// - bit 0 reads as the or of every event condition in the engine.
// - the event flag register is read-only, resets to 0, bits 31-4 read 0.
// - a disabled descriptor is refetched after the poll delay in cycles.
// - result words are written from the descriptor's update address.
// - the length word gives the byte count, processed exactly.
// - the offset word gives the cipher start offset or aad byte count.
// - poll delay resets to 0, low 16 bits read/write, upper bits read 0.
`timescale 1ns/1ns
module cdm_engine
   import cdm_pkg::*;
#(
   parameter int RESULT_WORDS = 4
)(
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire logic ce, // clock enable
   input wire logic [7:0] avs_address, // register byte address
   input wire logic avs_read, // register read request
   input wire logic avs_write, // register write request
   input wire logic [31:0] avs_writedata, // register write data
   input wire logic [3:0] avs_byteenable, // write byte lanes
   output logic [31:0] avs_readdata, // register read data
   output logic avs_waitrequest, // low for the answering cycle
   output logic mem_req, // memory request, held to ack
   output logic mem_we, // memory request is a write
   output logic [31:0] mem_addr, // memory byte address
   output logic [31:0] mem_wdata, // memory write data
   input wire logic [31:0] mem_rdata, // memory read data, with ack
   input wire logic mem_ack, // memory answer
   input wire logic mem_err, // memory answer is an error
   output logic cdp_valid, // one-cycle pulse: data word to datapath
   output logic [31:0] cdp_data, // message data word
   output logic [2:0] cdp_bytes, // valid bytes in cdp_data
   output logic [31:0] cdp_msg_len, // bytes of the length word still to send
   output logic [31:0] cdp_start_offset, // descriptor offset word
   input wire logic [RESULT_WORDS*32-1:0] cdp_result, // words to post
   output logic irq // interrupt request
);
   localparam int RIW = (RESULT_WORDS > 1) ? $clog2(RESULT_WORDS) : 1;
   localparam logic [RIW-1:0] RES_LAST = RIW'(RESULT_WORDS - 1);

   // bus side registers
   logic waitrequest_ff;
   logic [31:0] readdata_ff;
   logic [CDM_POLL_W-1:0] poll_ff;
   logic [31:0] base_ff;
   logic [3:1] flags_ff;
   logic irq_ff;
   // sequencer registers
   cdm_state_t state_ff;
   logic [2:0] widx_ff;
   logic [RIW-1:0] ridx_ff;
   logic [31:0] cur_ff;
   logic [31:0] src_ff;
   logic [31:0] upd_ff;
   logic [31:0] rem_ff;
   logic [31:0] off_ff;
   logic [31:0] next_ff;
   logic last_ff;
   logic req_ff;
   logic we_ff;
   logic [31:0] addr_ff;
   logic [31:0] wdata_ff;
   logic dvalid_ff;
   logic [31:0] ddata_ff;
   logic [2:0] dbytes_ff;
   logic ev_pkt_ff;
   logic ev_desc_ff;

   cdm_wait_if wt ();

   // merge write byte lanes into an old value
   function automatic logic [31:0] cdm_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : cdm_merge

   // exact address decode
   function automatic logic cdm_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
      return a == ofs;
   endfunction : cdm_hit

   logic wr_take;
   logic rd_take;
   logic start_go;
   logic [3:1] clr_req;
   logic ev_err;
   logic [2:0] step_bytes;
   logic [31:0] rem_after;
   logic [3:1] nxt_flags;

   assign wr_take = ce && avs_write && !waitrequest_ff;
   assign rd_take = ce && avs_read && waitrequest_ff;
   assign start_go = wr_take && cdm_hit(avs_address, CDM_OFS_CTRL)
                     && avs_byteenable[0] && avs_writedata[CDM_CTRL_START];
   // write ones to control bits 3:1 to clear flags
   assign clr_req = (wr_take && cdm_hit(avs_address, CDM_OFS_CTRL)
                     && avs_byteenable[0]) ? avs_writedata[3:1] : 3'h0;
   // an error answer from memory outside the engine
   assign ev_err = ce && req_ff && mem_ack && mem_err;
   // a word carries four bytes unless fewer remain
   assign step_bytes = (rem_ff >= CDM_WORD_BYTES) ? 3'h4
                       : rem_ff[2:0];
   assign rem_after = rem_ff - {29'h0, step_bytes};

   // answer one cycle after a request is first seen
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         waitrequest_ff <= 1'b1;
      end else if (ce) begin
         if ((avs_read || avs_write) && waitrequest_ff) begin
            waitrequest_ff <= 1'b0;
         end else begin
            waitrequest_ff <= 1'b1;
         end
      end
   end

   // read data captured so it stands at the answering edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         readdata_ff <= 32'h0000_0000;
      end else if (rd_take) begin
         unique case (avs_address)
            CDM_OFS_FLAGS: readdata_ff <= {28'h0, flags_ff, irq_ff};
            CDM_OFS_POLL: readdata_ff <= {16'h0, poll_ff};
            CDM_OFS_BASE: readdata_ff <= base_ff;
            CDM_OFS_STAT: readdata_ff <= {28'h0, state_ff,
                                          state_ff != CDM_IDLE};
            default: readdata_ff <= 32'h0000_0000; // unmapped and ctrl
         endcase
      end
   end

   // writable registers; the flag register ignores writes
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         poll_ff <= CDM_POLL_RESET;
         base_ff <= CDM_BASE_RESET;
      end else if (wr_take) begin
         if (cdm_hit(avs_address, CDM_OFS_POLL)) begin
            poll_ff <= CDM_POLL_W'(cdm_merge({16'h0, poll_ff}, avs_writedata,
                                 avs_byteenable));
         end
         if (cdm_hit(avs_address, CDM_OFS_BASE)) begin
            base_ff <= cdm_merge(base_ff, avs_writedata, avs_byteenable);
         end
      end
   end

   // sticky event flags: a set in the clearing cycle wins
   always_comb begin
      nxt_flags = flags_ff & ~clr_req;
      if (ev_err) begin
         nxt_flags[CDM_BIT_ACCESS_ERR] = 1'b1;
      end
      if (ev_pkt_ff) begin
         nxt_flags[CDM_BIT_PKT_DONE] = 1'b1;
      end
      if (ev_desc_ff) begin
         nxt_flags[CDM_BIT_DESC_DONE] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flags_ff <= CDM_FLAGS_RESET;
         irq_ff <= 1'b0;
      end else if (ce) begin
         flags_ff <= nxt_flags;
         // pending bit and the request line are one register
         irq_ff <= |nxt_flags;
      end
   end

   // timer starts on a disabled control word when the poll delay is nonzero
   assign wt.start = ce && (state_ff == CDM_FETCH) && req_ff && mem_ack
                     && !mem_err && (widx_ff == CDM_DW_CTRL)
                     && !mem_rdata[CDM_DESC_EN]
                     && (poll_ff != CDM_POLL_RESET);
   assign wt.cycles = poll_ff;

   cdm_poll_timer u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .wt(wt)
   );

   // sequencer and memory port; one request in flight
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_ff <= CDM_IDLE;
         widx_ff <= CDM_DW_CTRL;
         ridx_ff <= '0;
         cur_ff <= 32'h0000_0000;
         src_ff <= 32'h0000_0000;
         upd_ff <= 32'h0000_0000;
         rem_ff <= 32'h0000_0000;
         off_ff <= 32'h0000_0000;
         next_ff <= 32'h0000_0000;
         last_ff <= 1'b0;
         req_ff <= 1'b0;
         we_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         dvalid_ff <= 1'b0;
         ddata_ff <= 32'h0000_0000;
         dbytes_ff <= 3'h0;
         ev_pkt_ff <= 1'b0;
         ev_desc_ff <= 1'b0;
      end else if (ce) begin
         dvalid_ff <= 1'b0;
         ev_pkt_ff <= 1'b0;
         ev_desc_ff <= 1'b0;
         if (req_ff && mem_ack) begin
            req_ff <= 1'b0;
         end
         unique case (state_ff)
            CDM_IDLE: begin
               if (start_go) begin
                  cur_ff <= base_ff;
                  widx_ff <= CDM_DW_CTRL;
                  req_ff <= 1'b1;
                  we_ff <= 1'b0;
                  addr_ff <= base_ff;
                  state_ff <= CDM_FETCH;
               end
            end
            CDM_FETCH: begin
               if (req_ff && mem_ack) begin
                  if (mem_err) begin
                     // an error abandons the chain
                     state_ff <= CDM_IDLE;
                  end else begin
                     unique case (widx_ff)
                        CDM_DW_CTRL: begin
                           if (!mem_rdata[CDM_DESC_EN]) begin
                              // zero delay refetches at once
                              if (poll_ff == CDM_POLL_RESET) begin
                                 req_ff <= 1'b1;
                              end else begin
                                 state_ff <= CDM_POLL;
                              end
                           end else begin
                              last_ff <= mem_rdata[CDM_DESC_LAST];
                           end
                        end
                        CDM_DW_SRC: src_ff <= mem_rdata;
                        CDM_DW_UPD: upd_ff <= mem_rdata;
                        CDM_DW_LEN: rem_ff <= mem_rdata;
                        CDM_DW_OFF: off_ff <= mem_rdata;
                        default: next_ff <= mem_rdata;
                     endcase
                     if ((widx_ff != CDM_DW_CTRL)
                         || mem_rdata[CDM_DESC_EN]) begin
                        if (widx_ff == CDM_DW_NEXT) begin
                           req_ff <= 1'b1;
                           ridx_ff <= '0;
                           if (rem_ff == 32'h0000_0000) begin
                              // empty message: straight to results
                              we_ff <= 1'b1;
                              addr_ff <= upd_ff;
                              wdata_ff <= cdp_result[31:0];
                              state_ff <= CDM_RESULT;
                           end else begin
                              addr_ff <= src_ff;
                              state_ff <= CDM_DATA;
                           end
                        end else begin
                           widx_ff <= widx_ff + 3'h1;
                           addr_ff <= addr_ff + CDM_WORD_BYTES;
                           req_ff <= 1'b1;
                        end
                     end
                  end
               end
            end
            CDM_POLL: begin
               if (wt.done) begin
                  // refetch the same control word
                  req_ff <= 1'b1;
                  addr_ff <= cur_ff;
                  widx_ff <= CDM_DW_CTRL;
                  state_ff <= CDM_FETCH;
               end
            end
            CDM_DATA: begin
               if (req_ff && mem_ack) begin
                  if (mem_err) begin
                     state_ff <= CDM_IDLE;
                  end else begin
                     dvalid_ff <= 1'b1;
                     ddata_ff <= mem_rdata;
                     dbytes_ff <= step_bytes;
                     rem_ff <= rem_after;
                     src_ff <= src_ff + CDM_WORD_BYTES;
                     req_ff <= 1'b1;
                     if (rem_after == 32'h0000_0000) begin
                        we_ff <= 1'b1;
                        addr_ff <= upd_ff;
                        wdata_ff <= cdp_result[31:0];
                        state_ff <= CDM_RESULT;
                     end else begin
                        addr_ff <= src_ff + CDM_WORD_BYTES;
                     end
                  end
               end
            end
            CDM_RESULT: begin
               if (req_ff && mem_ack) begin
                  we_ff <= 1'b0;
                  if (mem_err) begin
                     state_ff <= CDM_IDLE;
                  end else if (ridx_ff == RES_LAST) begin
                     ev_pkt_ff <= 1'b1;
                     if (last_ff) begin
                        ev_desc_ff <= 1'b1;
                        state_ff <= CDM_IDLE;
                     end else begin
                        // next descriptor in the chain
                        cur_ff <= next_ff;
                        addr_ff <= next_ff;
                        widx_ff <= CDM_DW_CTRL;
                        req_ff <= 1'b1;
                        state_ff <= CDM_FETCH;
                     end
                  end else begin
                     we_ff <= 1'b1;
                     ridx_ff <= ridx_ff + RIW'(1);
                     addr_ff <= addr_ff + CDM_WORD_BYTES;
                     wdata_ff <= cdp_result[(32'(ridx_ff) + 1) * 32 +: 32];
                     req_ff <= 1'b1;
                  end
               end
            end
            default: state_ff <= CDM_IDLE;
         endcase
      end
   end

   // every output straight from a register
   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = waitrequest_ff;
   assign mem_req = req_ff;
   assign mem_we = we_ff;
   assign mem_addr = addr_ff;
   assign mem_wdata = wdata_ff;
   assign cdp_valid = dvalid_ff;
   assign cdp_data = ddata_ff;
   assign cdp_bytes = dbytes_ff;
   assign cdp_msg_len = rem_ff; // counts down as bytes are sent
   assign cdp_start_offset = off_ff;
   assign irq = irq_ff;
endmodule : cdm_engine

// >>> cdm_engine_props.sv
// checker for the cipher dma register port, memory port and irq
// assumes it is bound to cdm_engine and sees only its ports
`timescale 1ns/1ns
module cdm_engine_props
   import cdm_pkg::*;
#(
   parameter int RESULT_WORDS = 4
)(
   input wire logic sys_clk, // clock
   input wire logic reset, // sync reset
   input wire logic ce, // clock enable
   input wire logic [7:0] avs_address, // register address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // answer strobe, low
   input wire logic mem_req, // memory request
   input wire logic mem_we, // memory write
   input wire logic [31:0] mem_addr, // memory address
   input wire logic mem_ack, // memory answer
   input wire logic mem_err, // memory error
   input wire logic cdp_valid, // data word pulse
   input wire logic [2:0] cdp_bytes, // valid bytes
   input wire logic irq // interrupt request
);
   // answered reads of the flag and poll registers
   logic rd_ans, rd_flags, rd_poll;
   assign rd_ans = avs_read && !avs_waitrequest;
   assign rd_flags = rd_ans && avs_address == CDM_OFS_FLAGS;
   assign rd_poll = rd_ans && avs_address == CDM_OFS_POLL;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_answer_one_cycle: assert property (
      (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
      else $error("request not answered");
   a_answer_single: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset && ce |=> avs_waitrequest && !mem_req && !irq && !cdp_valid)
      else $error("not idle after reset");
   a_flags_upper_zero: assert property (
      rd_flags |-> avs_readdata[31:4] == 28'h0)
      else $error("flag bits 31-4 set");
   a_pending_has_cause: assert property (
      rd_flags && avs_readdata[CDM_BIT_PENDING] |-> |avs_readdata[3:1])
      else $error("pending set with no event");
   a_cause_drives_irq: assert property (
      rd_flags && |avs_readdata[3:1] |-> irq)
      else $error("flag set, irq low");
   a_poll_upper_zero: assert property (
      rd_poll |-> avs_readdata[31:16] == 16'h0)
      else $error("poll bits 31-16 set");
   a_req_held: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("request moved before ack");
   a_valid_after_ack: assert property (
      cdp_valid |-> $past(mem_ack) && !$past(mem_we)
         && cdp_bytes inside {[3'h1:3'h4]})
      else $error("pulse without read ack");
   a_error_stops: assert property (
      mem_ack && mem_err |=> !mem_req [*4])
      else $error("request after error");

   // main scenarios reached
   c_flag_read: cover property (rd_flags && avs_readdata[3]);
   c_mem_error: cover property (mem_ack && mem_err);
   c_short_word: cover property (cdp_valid && cdp_bytes == 3'h3);
   c_irq_rise: cover property ($rose(irq));
endmodule : cdm_engine_props

bind cdm_engine cdm_engine_props #(.RESULT_WORDS(RESULT_WORDS)) props_i (
   .sys_clk(sys_clk), .reset(reset), .ce(ce), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err),
   .cdp_valid(cdp_valid), .cdp_bytes(cdp_bytes), .irq(irq));

// >>> cdm_engine_tb.sv
// self-checking bench for the cipher dma status and descriptor block
// assumes the package, timer and memory model are compiled
`timescale 1ns/1ns
module cdm_engine_tb;
   import cdm_pkg::*;
   localparam int RW = 4;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, mem_addr, mem_wdata, mem_rdata, cdp_data;
   logic [31:0] cdp_msg_len, cdp_start_offset, first_off;
   logic avs_waitrequest, mem_req, mem_we, mem_ack, mem_err, cdp_valid, irq;
   logic [2:0] cdp_bytes;
   logic [RW*32-1:0] cdp_result = {32'hc0de_0003, 32'hc0de_0002,
      32'hc0de_0001, 32'hc0de_0000};
   logic [2:0] lat = 3'h0;
   logic [31:0] err_addr = 32'hffff_fffc;
   logic [31:0] probe = 32'h0;
   logic [31:0] d;
   logic [2:0] vbytes[$];
   int acks[$];
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;

   cdm_engine #(.RESULT_WORDS(RW)) cdm_engine_i (.sys_clk(sys_clk),
      .reset(reset), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .mem_err(mem_err), .cdp_valid(cdp_valid),
      .cdp_data(cdp_data), .cdp_bytes(cdp_bytes), .cdp_msg_len(cdp_msg_len),
      .cdp_start_offset(cdp_start_offset), .cdp_result(cdp_result), .irq(irq));
   cdm_mem_model cdm_mem_model_i (.sys_clk(sys_clk), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
      .lat(lat), .err_addr(err_addr));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   // data pulses and ack times of the probed word
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cdp_valid === 1'b1 && vbytes.size() == 0)
         first_off = cdp_start_offset;
      if (cdp_valid === 1'b1) vbytes.push_back(cdp_bytes);
      if (mem_ack === 1'b1 && mem_we === 1'b0 && mem_addr === probe)
         acks.push_back(cyc);
   end

   task chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // request held until waitrequest is sampled low
   task bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd = 32'h0, input logic [3:0] be = 4'hf);
      int n;
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
   endtask : bus
   task rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a);
      chk(d, e);
   endtask : rdc
   task wait_idle;
      int n;
      n = 0;
      do begin
         bus(1'b0, CDM_OFS_STAT);
         n++;
      end while (d[0] !== 1'b0 && n < 400);
      chk(32'(n < 400), 32'h1);
   endtask : wait_idle
   task put_desc(input logic [31:0] a, c, s, u, l, o, nx);
      logic [31:0] w[6];
      w = '{c, s, u, l, o, nx};
      for (int i = 0; i < 6; i++) cdm_mem_model_i.words[a[11:2] + i] = w[i];
   endtask : put_desc
   task start(input logic [31:0] base);
      vbytes.delete();
      bus(1'b1, CDM_OFS_BASE, base);
      bus(1'b1, CDM_OFS_CTRL, 32'h1);
   endtask : start

   task t_regs;
      rdc(CDM_OFS_FLAGS, 32'h0);
      rdc(CDM_OFS_POLL, 32'h0);
      bus(1'b1, CDM_OFS_FLAGS, 32'hffff_ffff);
      rdc(CDM_OFS_FLAGS, 32'h0);
      bus(1'b1, CDM_OFS_POLL, 32'hffff_ffff);
      rdc(CDM_OFS_POLL, 32'h0000_ffff);
      bus(1'b1, CDM_OFS_POLL, 32'h1234_5678, 4'h1);
      rdc(CDM_OFS_POLL, 32'h0000_ff78);
      rdc(8'h20, 32'h0);
      bus(1'b1, CDM_OFS_POLL, 32'h0);
   endtask : t_regs
   // two linked descriptors, the first with a short last word
   task t_chain;
      lat = 3'h2;
      put_desc(32'h100, 32'h8000_0000, 32'h200, 32'h300, 32'h7, 32'h5, 32'h140);
      put_desc(32'h140, 32'hc000_0000, 32'h220, 32'h340, 32'h4, 32'h9, 32'h0);
      cdm_mem_model_i.words[8'h88] = 32'hfeed_0123;
      start(32'h100);
      wait_idle;
      chk(32'(vbytes.size()), 32'h3);
      chk(32'(vbytes[1]), 32'h3);
      chk(first_off, 32'h5);
      chk(cdp_data, 32'hfeed_0123);
      chk(cdp_msg_len, 32'h0);
      for (int i = 0; i < RW; i++) begin
         chk(cdm_mem_model_i.words[8'hc0 + i], cdp_result[i*32 +: 32]);
         chk(cdm_mem_model_i.words[8'hd0 + i], cdp_result[i*32 +: 32]);
      end
      rdc(CDM_OFS_FLAGS, 32'h7);
      chk(32'(irq), 32'h1);
      bus(1'b1, CDM_OFS_CTRL, 32'he);
      rdc(CDM_OFS_FLAGS, 32'h0);
      chk(32'(irq), 32'h0);
   endtask : t_chain
   // refetch gap of a disabled descriptor
   task gap(output int g);
      int n;
      acks.delete();
      n = 0;
      while (acks.size() < 3 && n < 500) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(acks.size() >= 3), 32'h1);
      g = (acks.size() >= 3) ? acks[2] - acks[1] : 0;
   endtask : gap
   task t_poll;
      int g0, g1;
      lat = 3'h0;
      probe = 32'h180;
      put_desc(32'h180, 32'h0, 32'h200, 32'h380, 32'h4, 32'h0, 32'h0);
      start(32'h180);
      gap(g0);
      bus(1'b1, CDM_OFS_POLL, 32'hc);
      gap(g1);
      chk(32'(g1 - g0), 32'hc);
      cdm_mem_model_i.words[8'h60] = 32'hc000_0000;
      wait_idle;
      rdc(CDM_OFS_FLAGS, 32'h7);
      bus(1'b1, CDM_OFS_CTRL, 32'he);
      bus(1'b1, CDM_OFS_POLL, 32'h0);
   endtask : t_poll
   // error on the second data word ends the chain
   task t_error;
      lat = 3'h1;
      err_addr = 32'h244;
      put_desc(32'h1c0, 32'hc000_0000, 32'h240, 32'h3c0, 32'h8, 32'h0, 32'h0);
      start(32'h1c0);
      wait_idle;
      rdc(CDM_OFS_FLAGS, 32'h9);
      chk(32'(vbytes.size()), 32'h1);
      chk(32'(irq), 32'h1);
   endtask : t_error

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // tests after eight reset cycles
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs;
      t_chain;
      t_poll;
      t_error;
      finish_test;
   end
   // watchdog far past the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test;
   end
endmodule : cdm_engine_tb

// >>> cdm_mem_model.sv
// system memory model answering the dma with req/ack
// assumes word addresses below 4 KiB and a held request
`timescale 1ns/1ns
module cdm_mem_model (
   input wire logic sys_clk, // clock
   input wire logic mem_req, // request
   input wire logic mem_we, // write
   input wire logic [31:0] mem_addr, // address
   input wire logic [31:0] mem_wdata, // write data
   output logic [31:0] mem_rdata, // read data
   output logic mem_ack, // answer pulse
   output logic mem_err, // error with ack
   input wire logic [2:0] lat, // wait cycles before ack
   input wire logic [31:0] err_addr // address that fails
);
   logic [31:0] words [0:1023];
   logic [2:0] cnt;
   initial begin
      mem_ack = 1'b0;
      mem_err = 1'b0;
      mem_rdata = 32'h5a5a_a5a5;
      cnt = 3'h0;
   end
   // data toggles outside acks so stale words are never mistaken
   always @(posedge sys_clk) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         cnt <= cnt + 3'h1;
         if (cnt == lat) begin
            cnt <= 3'h0;
            mem_ack <= 1'b1;
            mem_err <= (mem_addr == err_addr);
            if (mem_we) words[mem_addr[11:2]] <= mem_wdata;
            else mem_rdata <= words[mem_addr[11:2]];
         end
      end
   end
endmodule : cdm_mem_model

// >>> cdm_pkg.sv
// constants and types shared by the cipher dma status/descriptor block
// assumes a 32-bit avalon-mm register port and 32-bit memory words
package cdm_pkg;
   // register byte offsets
   localparam logic [7:0] CDM_OFS_FLAGS = 8'h00;
   localparam logic [7:0] CDM_OFS_POLL = 8'h04;
   localparam logic [7:0] CDM_OFS_CTRL = 8'h08;
   localparam logic [7:0] CDM_OFS_BASE = 8'h0c;
   localparam logic [7:0] CDM_OFS_STAT = 8'h10;
   // event flag bit positions
   localparam int CDM_BIT_ACCESS_ERR = 3;
   localparam int CDM_BIT_PKT_DONE = 2;
   localparam int CDM_BIT_DESC_DONE = 1;
   localparam int CDM_BIT_PENDING = 0;
   localparam logic [3:1] CDM_FLAGS_RESET = 3'h0;
   // poll delay field
   localparam int CDM_POLL_W = 16;
   localparam logic [15:0] CDM_POLL_RESET = 16'h0000;
   // control register fields
   localparam int CDM_CTRL_START = 0;
   localparam logic [31:0] CDM_BASE_RESET = 32'h0000_0000;
   // descriptor word indices and control word fields
   localparam logic [2:0] CDM_DW_CTRL = 3'h0;
   localparam logic [2:0] CDM_DW_SRC = 3'h1;
   localparam logic [2:0] CDM_DW_UPD = 3'h2;
   localparam logic [2:0] CDM_DW_LEN = 3'h3;
   localparam logic [2:0] CDM_DW_OFF = 3'h4;
   localparam logic [2:0] CDM_DW_NEXT = 3'h5;
   localparam int CDM_DESC_EN = 31;
   localparam int CDM_DESC_LAST = 30;
   localparam logic [31:0] CDM_WORD_BYTES = 32'h0000_0004;
   typedef enum logic [2:0] {
      CDM_IDLE = 3'b000,
      CDM_FETCH = 3'b001,
      CDM_POLL = 3'b010,
      CDM_DATA = 3'b011,
      CDM_RESULT = 3'b100
   } cdm_state_t;
endpackage : cdm_pkg

// >>> cdm_poll_timer.sv
// poll delay timer: counts system clock cycles before a refetch
// assumes start is a one-cycle pulse with a nonzero cycle count
`timescale 1ns/1ns
module cdm_poll_timer
   import cdm_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire logic ce, // clock enable, freezes state when low
   cdm_wait_if.tmr wt // start, count and done
);
   logic [CDM_POLL_W-1:0] cnt_ff;

   // load on start, then count down to zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_ff <= CDM_POLL_RESET;
      end else if (ce) begin
         if (wt.start) begin
            cnt_ff <= wt.cycles;
         end else if (cnt_ff != CDM_POLL_RESET) begin
            cnt_ff <= cnt_ff - 16'h0001;
         end
      end
   end

   // done in the last counted cycle; gated off while frozen
   assign wt.done = ce && (cnt_ff == 16'h0001);
endmodule : cdm_poll_timer

// >>> cdm_wait_if.sv
// handshake between the sequencer and the poll delay timer
// assumes both ends share sys_clk
`timescale 1ns/1ns
interface cdm_wait_if;
   logic start;
   logic [15:0] cycles;
   logic done;
   modport ctl (output start, output cycles, input done);
   modport tmr (input start, input cycles, output done);
endinterface : cdm_wait_if
